// ===== hdl/srpd_stream_read_decode.sv
/*
 * Streaming-read command parameter decoder and time-limit keeper.
 * Assumes a plain register port on mclk, and a media engine that
 * reports sector progress, errors and the failing address.
 */
`timescale 1ns/1ps
`default_nettype none
module srpd_stream_read_decode
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire logic [4:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   // Media engine side
   output logic readStart,
   output logic [47:0] readLba,
   output logic [16:0] readCount,
   output logic [srpd_pkg::SEL_MSB:0] readStream,
   output logic readNotSeq,
   output logic readHalt,
   input wire logic sectorDone,
   input wire logic sectorErr,
   input wire logic fatalErr,
   input wire logic [47:0] failLba,
   // Status to the command interface
   output logic busy,
   output logic cmdDone
);
   import srpd_pkg::*;

   localparam int SW = SEL_MSB + 1;

   // Saturate a wide product into the limit register width
   function automatic logic [23:0] sat24(input logic [23:0] v, input logic hi);
      sat24 = hi ? 24'hFFFFFF : v;
   endfunction

   // ======================================================
   // Register state
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [7:0] factor_r, factor_nxt;
   logic [15:0] len_r, len_nxt;
   logic [47:0] addr_r, addr_nxt;
   logic [15:0] unit_r, unit_nxt;
   logic [SW-1:0] cfgSel_r, cfgSel_nxt;
   logic [15:0] dflt_r [NUM_STREAMS];
   logic [15:0] dflt_nxt [NUM_STREAMS];
   logic [NUM_STREAMS-1:0] cfgd_r, cfgd_nxt;
   logic [47:0] errLba_r [NUM_STREAMS];
   logic [47:0] errLba_nxt [NUM_STREAMS];
   // Command state
   srpd_state_t state_r, state_nxt;
   logic [23:0] limit_r, limit_nxt;
   logic limitOn_r, limitOn_nxt;
   logic [23:0] elapsed_r, elapsed_nxt;
   logic [7:0] tick_r, tick_nxt;
   logic [16:0] left_r, left_nxt;
   logic [7:0] status_r, status_nxt;
   logic [7:0] error_r, error_nxt;
   logic [47:0] retLba_r, retLba_nxt;
   logic haveFail_r, haveFail_nxt;
   logic contMode_r, contMode_nxt;
   logic [SW-1:0] sel_r, sel_nxt;
   // Output registers
   logic [31:0] rd_r, rd_nxt;
   logic start_r, start_nxt;
   logic [47:0] lbaOut_r, lbaOut_nxt;
   logic [16:0] cntOut_r, cntOut_nxt;
   logic ns_r, ns_nxt;
   logic halt_r, halt_nxt;
   logic done_r, done_nxt;

   // Combinational helpers for command launch
   logic [SW-1:0] cmdSel;
   logic [31:0] rawLimit;
   logic [15:0] useFactor;
   logic [39:0] prod;
   logic [23:0] clampLim;
   logic cmdWrite;
   logic expired;

   // ======================================================
   // Launch decode: stream select, command strobe and clamped limit of a new command
   always_comb
   begin
      cmdSel = ctrl_r[SEL_MSB:0];
      cmdWrite = regWr && regAddr == ADDR_COMMAND
         && regWrData[7:0] == CMD_STREAM_READ && state_r != RUN;
      useFactor = (factor_r != 8'h00) ? {8'h00, factor_r} : dflt_r[cmdSel];
      prod = 40'(useFactor) * 40'(unit_r);
      rawLimit = prod[31:0];
      clampLim = sat24(prod[23:0], |prod[39:24]);
      if (clampLim < MIN_LIMIT_US)
      begin
         clampLim = MIN_LIMIT_US;
      end
      rawLimit = {8'h00, clampLim};
   end

   // Limit has run out when the microsecond count reaches it
   assign expired = limitOn_r && elapsed_r >= limit_r;

   // ======================================================
   // Next-state logic for registers and the command sequence
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      factor_nxt = factor_r;
      len_nxt = len_r;
      addr_nxt = addr_r;
      unit_nxt = unit_r;
      cfgSel_nxt = cfgSel_r;
      dflt_nxt = dflt_r;
      cfgd_nxt = cfgd_r;
      errLba_nxt = errLba_r;
      state_nxt = state_r;
      limit_nxt = limit_r;
      limitOn_nxt = limitOn_r;
      elapsed_nxt = elapsed_r;
      tick_nxt = tick_r;
      left_nxt = left_r;
      status_nxt = status_r;
      error_nxt = error_r;
      retLba_nxt = retLba_r;
      haveFail_nxt = haveFail_r;
      contMode_nxt = contMode_r;
      sel_nxt = sel_r;
      rd_nxt = 32'h0000_0000;
      start_nxt = 1'b0;
      lbaOut_nxt = lbaOut_r;
      cntOut_nxt = cntOut_r;
      ns_nxt = ns_r;
      halt_nxt = 1'b0;
      done_nxt = 1'b0;
      // Parameter writes; the block is write-only except the time unit, and busy is ignored
      if (regWr)
      begin
         unique case (regAddr)
            ADDR_STREAM_CTRL: ctrl_nxt = regWrData[7:0];
            ADDR_TL_FACTOR: factor_nxt = regWrData[7:0];
            ADDR_LEN_LO: len_nxt[7:0] = regWrData[7:0];
            ADDR_LEN_HI: len_nxt[15:8] = regWrData[7:0];
            ADDR_SA0: addr_nxt[7:0] = regWrData[7:0];
            ADDR_SA1: addr_nxt[15:8] = regWrData[7:0];
            ADDR_SA2: addr_nxt[23:16] = regWrData[7:0];
            ADDR_SA3: addr_nxt[31:24] = regWrData[7:0];
            ADDR_SA4: addr_nxt[39:32] = regWrData[7:0];
            ADDR_SA5: addr_nxt[47:40] = regWrData[7:0];
            ADDR_TIME_UNIT: unit_nxt = regWrData[15:0];
            ADDR_CFG_STREAM: cfgSel_nxt = regWrData[SEL_MSB:0];
            ADDR_CFG_DEFAULT:
            begin
               // Stream configuration stores a default per stream
               dflt_nxt[cfgSel_r] = regWrData[15:0];
               cfgd_nxt[cfgSel_r] = 1'b1;
            end
            default: ;
         endcase
      end
      // Register reads answer one cycle later; unmapped reads give zero
      if (regRd)
      begin
         unique case (regAddr)
            ADDR_STATUS: rd_nxt = {24'h000000, status_r};
            ADDR_ERROR: rd_nxt = {24'h000000, error_r};
            ADDR_LBA_LO: rd_nxt = retLba_r[31:0];
            ADDR_LBA_HI: rd_nxt = {16'h0000, retLba_r[47:32]};
            ADDR_LIMIT: rd_nxt = {7'h00, limitOn_r, limit_r};
            ADDR_COUNT: rd_nxt = {15'h0000, left_r};
            ADDR_TIME_UNIT: rd_nxt = {16'h0000, unit_r};
            ADDR_EXTRA_ST: rd_nxt = {29'h0, haveFail_r, contMode_r, busy};
            default: rd_nxt = 32'h0000_0000;
         endcase
      end
      unique case (state_r)
         IDLE, DONE:
         begin
            if (cmdWrite)
            begin
               // Timing starts at the command register write
               state_nxt = RUN;
               sel_nxt = cmdSel;
               contMode_nxt = ctrl_r[CONT_READ_BIT];
               ns_nxt = ctrl_r[NOT_SEQ_BIT];
               limit_nxt = rawLimit[23:0];
               limitOn_nxt = (factor_r != 8'h00)
                  || (cfgd_r[cmdSel] && dflt_r[cmdSel] != 16'h0000);
               elapsed_nxt = 24'h000000;
               tick_nxt = 8'h00;
               left_nxt = (len_r == 16'h0000) ? FULL_LENGTH : {1'b0, len_r};
               cntOut_nxt = left_nxt;
               lbaOut_nxt = ctrl_r[RESUME_BIT] ? errLba_r[cmdSel] : addr_r;
               start_nxt = 1'b1;
               status_nxt = 8'h00;
               status_nxt[ST_BUSY_BIT] = 1'b1;
               error_nxt = 8'h00;
               haveFail_nxt = 1'b0;
            end
         end
         RUN:
         begin
            // Microsecond tick from the clock divider
            if (tick_r == TICK_LAST)
            begin
               tick_nxt = 8'h00;
               if (elapsed_r != 24'hFFFFFF)
                  elapsed_nxt = elapsed_r + 24'h000001;
            end
            else
               tick_nxt = tick_r + 8'h01;
            // Errors: continuous mode keeps going and flags stream error
            if (sectorErr || fatalErr)
            begin
               if (contMode_r)
                  status_nxt[ST_SERR_BIT] = 1'b1;
               if (!haveFail_r)
               begin
                  retLba_nxt = failLba;
                  errLba_nxt[sel_r] = failLba;
                  haveFail_nxt = 1'b1;
               end
            end
            if (sectorDone && left_r != 17'h00000)
               left_nxt = left_r - 17'h00001;
            if (expired)
            begin
               // Halt on limit expiry, timeout noted in the error log
               state_nxt = DONE;
               halt_nxt = 1'b1;
               done_nxt = 1'b1;
               error_nxt[ER_TLX_BIT] = 1'b1;
               status_nxt[ST_BUSY_BIT] = 1'b0;
               if (contMode_r)
               begin
                  status_nxt[ST_SERR_BIT] = 1'b1;
                  status_nxt[ST_ERR_BIT] = 1'b0;
               end
               else
                  status_nxt[ST_ERR_BIT] = 1'b1;
            end
            else if (fatalErr && !contMode_r)
            begin
               // Normal mode aborts on an unrecoverable error
               state_nxt = DONE;
               halt_nxt = 1'b1;
               done_nxt = 1'b1;
               error_nxt[ER_ABRT_BIT] = 1'b1;
               status_nxt[ST_BUSY_BIT] = 1'b0;
               status_nxt[ST_ERR_BIT] = 1'b1;
            end
            else if (left_nxt == 17'h00000)
            begin
               // All sectors delivered; errors never set ERR in continuous mode
               state_nxt = DONE;
               done_nxt = 1'b1;
               status_nxt[ST_BUSY_BIT] = 1'b0;
            end
         end
         default: state_nxt = IDLE;
      endcase
   end

   // ======================================================
   // Registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r <= 8'h00;
         factor_r <= 8'h00;
         len_r <= 16'h0000;
         addr_r <= 48'h0;
         unit_r <= TIME_UNIT_RESET;
         cfgSel_r <= '0;
         for (int i = 0; i < NUM_STREAMS; i++)
         begin
            dflt_r[i] <= 16'h0000;
            errLba_r[i] <= 48'h0;
         end
         cfgd_r <= '0;
         state_r <= IDLE;
         limit_r <= 24'h000000;
         limitOn_r <= 1'b0;
         elapsed_r <= 24'h000000;
         tick_r <= 8'h00;
         left_r <= 17'h00000;
         status_r <= 8'h00;
         error_r <= 8'h00;
         retLba_r <= 48'h0;
         haveFail_r <= 1'b0;
         contMode_r <= 1'b0;
         sel_r <= '0;
         rd_r <= 32'h0000_0000;
         start_r <= 1'b0;
         lbaOut_r <= 48'h0;
         cntOut_r <= 17'h00000;
         ns_r <= 1'b0;
         halt_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         factor_r <= factor_nxt;
         len_r <= len_nxt;
         addr_r <= addr_nxt;
         unit_r <= unit_nxt;
         cfgSel_r <= cfgSel_nxt;
         dflt_r <= dflt_nxt;
         errLba_r <= errLba_nxt;
         cfgd_r <= cfgd_nxt;
         state_r <= state_nxt;
         limit_r <= limit_nxt;
         limitOn_r <= limitOn_nxt;
         elapsed_r <= elapsed_nxt;
         tick_r <= tick_nxt;
         left_r <= left_nxt;
         status_r <= status_nxt;
         error_r <= error_nxt;
         retLba_r <= retLba_nxt;
         haveFail_r <= haveFail_nxt;
         contMode_r <= contMode_nxt;
         sel_r <= sel_nxt;
         rd_r <= rd_nxt;
         start_r <= start_nxt;
         lbaOut_r <= lbaOut_nxt;
         cntOut_r <= cntOut_nxt;
         ns_r <= ns_nxt;
         halt_r <= halt_nxt;
         done_r <= done_nxt;
      end
   end

   // ======================================================
   // Outputs, all from flip-flops
   assign regRdData = rd_r;
   assign readStart = start_r;
   assign readLba = lbaOut_r;
   assign readCount = cntOut_r;
   assign readStream = sel_r;
   assign readNotSeq = ns_r;
   assign readHalt = halt_r;
   assign busy = status_r[ST_BUSY_BIT];
   assign cmdDone = done_r;
endmodule
`default_nettype wire

// ===== shared/srpd_pkg.sv
/*
 * Constants for the streaming-read parameter decoder: register map,
 * field positions, widths, and timing figures.
 * Assumes a single 200 MHz controller clock.
 */
package srpd_pkg;
   // ======================================================
   // Register map (word index on the plain register port)
   localparam logic [4:0] ADDR_STREAM_CTRL = 5'h00;
   localparam logic [4:0] ADDR_TL_FACTOR = 5'h01;
   localparam logic [4:0] ADDR_LEN_LO = 5'h02;
   localparam logic [4:0] ADDR_LEN_HI = 5'h03;
   localparam logic [4:0] ADDR_SA0 = 5'h04;
   localparam logic [4:0] ADDR_SA3 = 5'h05;
   localparam logic [4:0] ADDR_SA1 = 5'h06;
   localparam logic [4:0] ADDR_SA4 = 5'h07;
   localparam logic [4:0] ADDR_SA2 = 5'h08;
   localparam logic [4:0] ADDR_SA5 = 5'h09;
   localparam logic [4:0] ADDR_COMMAND = 5'h0A;
   localparam logic [4:0] ADDR_TIME_UNIT = 5'h0B;
   localparam logic [4:0] ADDR_CFG_STREAM = 5'h0C;
   localparam logic [4:0] ADDR_CFG_DEFAULT = 5'h0D;
   localparam logic [4:0] ADDR_STATUS = 5'h0E;
   localparam logic [4:0] ADDR_ERROR = 5'h0F;
   localparam logic [4:0] ADDR_LBA_LO = 5'h10;
   localparam logic [4:0] ADDR_LBA_HI = 5'h11;
   localparam logic [4:0] ADDR_LIMIT = 5'h12;
   localparam logic [4:0] ADDR_COUNT = 5'h13;
   localparam logic [4:0] ADDR_EXTRA_ST = 5'h14;
   // ======================================================
   // Field positions
   localparam int CONT_READ_BIT = 6;
   localparam int NOT_SEQ_BIT = 5;
   localparam int RESUME_BIT = 4;
   localparam int SEL_MSB = 2;
   localparam int ST_BUSY_BIT = 7;
   localparam int ST_SERR_BIT = 5;
   localparam int ST_ERR_BIT = 0;
   localparam int ER_ABRT_BIT = 2;
   localparam int ER_TLX_BIT = 0;
   // ======================================================
   // Command codes, widths, reset values
   localparam logic [7:0] CMD_STREAM_READ = 8'h2B;
   localparam int NUM_STREAMS = 8;
   localparam logic [16:0] FULL_LENGTH = 17'h10000;
   localparam logic [15:0] TIME_UNIT_RESET = 16'h0001;
   // ======================================================
   // Timing: 1 us tick at 200 MHz, built-in minimum limit
   localparam int CLK_MHZ = 200;
   localparam int US_NS = 1000;
   localparam int CLK_NS = US_NS / CLK_MHZ;
   localparam int TICK_CYCLES = US_NS / CLK_NS;
   localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
   localparam logic [23:0] MIN_LIMIT_US = 24'h000064;
   // ======================================================
   typedef enum logic [1:0] {IDLE, RUN, DONE} srpd_state_t;
endpackage

// ===== tb/srpd_decode_sva.sv
/*
 * Port assertions for the streaming-read decoder.
 * Assumes it is bound onto srpd_stream_read_decode, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module srpd_decode_sva
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire logic [4:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdData,
   // Engine and status
   input wire logic readStart,
   input wire logic [16:0] readCount,
   input wire logic readHalt,
   input wire logic busy,
   input wire logic cmdDone
);
   import srpd_pkg::*;
   // ======================================================
   // Command launch and completion
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic launch;
   // A command write is only honoured when the code matches
   assign launch = regWr && regAddr == ADDR_COMMAND && regWrData[7:0] == CMD_STREAM_READ;
   chk_cmd_launch: assert property (launch && !busy |=> readStart)
      else $error("command write did not launch");
   chk_busy_block: assert property (launch && busy |=> !readStart)
      else $error("command launched while busy");
   chk_start_busy: assert property (readStart |-> busy ##1 !readStart)
      else $error("start pulse without busy");
   chk_count_range: assert property (readStart |-> readCount != 17'h0 && readCount <= FULL_LENGTH)
      else $error("sector count out of range");
   chk_done_fall: assert property ($fell(busy) |-> cmdDone)
      else $error("busy fell without completion");
   chk_done_idle: assert property (cmdDone |-> !busy ##1 !cmdDone)
      else $error("completion pulse malformed");
   chk_halt_idle: assert property (readHalt |-> !busy)
      else $error("halt while still busy");
   chk_halt_done: assert property (readHalt |-> cmdDone)
      else $error("halt without completion pulse");
   // Read data must be quiet outside its slot, or a host mux would see junk
   chk_read_quiet: assert property (!$past(regRd) |-> regRdData == 32'h0)
      else $error("read data outside its slot");
endmodule
bind srpd_stream_read_decode srpd_decode_sva chk
(
   .mclk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
   .readStart, .readCount, .readHalt, .busy, .cmdDone
);
`default_nettype wire

// ===== tb/srpd_media_model.sv
/*
 * Media engine stand-in for the decoder bench.
 * Assumes the bench sets mode: 0 deliver, 1 stall, 2 one soft error then stall,
 * 3 one fatal error.
 */
`timescale 1ns/1ps
`default_nettype none
module srpd_media_model
#(
   parameter logic [47:0] ERR_LBA = 48'h0
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Command from the decoder
   input wire logic readStart,
   input wire logic [16:0] readCount,
   input wire logic readHalt,
   // Bench control
   input wire logic [1:0] mode,
   // Progress back to the decoder
   output logic sectorDone,
   output logic sectorErr,
   output logic fatalErr,
   output logic [47:0] failLba
);
   logic [16:0] left_r;
   logic tog_r;
   logic once_r;
   // ======================================================
   // One sector every other cycle, so the decoder sees gaps
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         left_r <= 17'h0;
         tog_r <= 1'b0;
         once_r <= 1'b0;
         sectorDone <= 1'b0;
         sectorErr <= 1'b0;
         fatalErr <= 1'b0;
      end
      else
      begin
         sectorDone <= 1'b0;
         sectorErr <= 1'b0;
         fatalErr <= 1'b0;
         tog_r <= !tog_r;
         if (readStart)
         begin
            left_r <= readCount;
            once_r <= 1'b1;
         end
         else if (readHalt)
            left_r <= 17'h0;
         else if (left_r != 17'h0)
         begin
            if (mode == 2'h0 && tog_r)
            begin
               sectorDone <= 1'b1;
               left_r <= left_r - 17'h1;
            end
            if (mode[1] && once_r)
            begin
               sectorErr <= !mode[0];
               fatalErr <= mode[0];
               once_r <= 1'b0;
            end
         end
      end
   end
   // Address is only valid beside an error; otherwise it toggles
   assign failLba = (sectorErr || fatalErr) ? ERR_LBA : {24{tog_r, !tog_r}};
endmodule
`default_nettype wire

// ===== tb/test_stream_read_param_decode.sv
/*
 * Self-checking bench for the streaming-read decoder.
 * Assumes the media model on the far side and 200 MHz mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module test_stream_read_param_decode;
   import srpd_pkg::*;
   localparam logic [47:0] ERR_LBA = 48'h00AB_CDEF_0123;
   // ======================================================
   // Stimulus and hookup
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] regAddr = 5'h00;
   logic [31:0] regWrData = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [1:0] mode = 2'h1;
   logic [31:0] regRdData;
   logic readStart, readHalt, readNotSeq, busy, cmdDone, sectorDone, sectorErr, fatalErr;
   logic [47:0] readLba, failLba;
   logic [16:0] readCount;
   logic [2:0] readStream;
   int miscompares = 0;
   int nCompared = 0;
   int cyc = 0;
   int t0 = 0;
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   srpd_stream_read_decode dut (.mclk, .rst, .regAddr, .regWrData, .regWr, .regRd,
      .regRdData, .readStart, .readLba, .readCount, .readStream, .readNotSeq, .readHalt,
      .sectorDone, .sectorErr, .fatalErr, .failLba, .busy, .cmdDone);
   srpd_media_model #(.ERR_LBA(ERR_LBA)) eng (.mclk, .rst, .readStart, .readCount,
      .readHalt, .mode, .sectorDone, .sectorErr, .fatalErr, .failLba);
   // ======================================================
   // Bus cycles and comparison
   task automatic cmp(input string nm, input logic [47:0] e, input logic [47:0] g);
      nCompared++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   // Masked read compare; data stands only in the cycle after the strobe
   task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] m,
      input logic [31:0] e);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      cmp(nm, {16'h0, e & m}, {16'h0, regRdData & m});
   endtask
   task automatic launch(input logic [7:0] c, input logic [7:0] f, input logic [15:0] n,
      input logic [1:0] md);
      mode <= md;
      wr(ADDR_STREAM_CTRL, {24'h0, c});
      wr(ADDR_TL_FACTOR, {24'h0, f});
      wr(ADDR_LEN_LO, {24'h0, n[7:0]});
      wr(ADDR_LEN_HI, {24'h0, n[15:8]});
      wr(ADDR_COMMAND, {24'h0, CMD_STREAM_READ});
      t0 = cyc;
      #1;
      cmp("start", 48'h1, {47'h0, readStart});
   endtask
   // Limit of zero means plain completion; else end must fall within one tick of it
   task automatic wait_done(input int lim);
      int n;
      n = 0;
      while (cmdDone !== 1'b1 && n < 40000)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (lim > 0)
         cmp("end time", 48'h1, {47'h0, (cyc - t0 > (lim - 1) * TICK_CYCLES)
            && (cyc - t0 < lim * TICK_CYCLES + TICK_CYCLES + 4)});
      else
         cmp("done", 48'h1, {47'h0, cmdDone});
   endtask
   // ======================================================
   // Scenarios
   task automatic test_reset;
      rdc("status", ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
      rdc("time unit", ADDR_TIME_UNIT, 32'hFFFF, {16'h0, TIME_UNIT_RESET});
      wr(5'h1E, 32'hFF);
      rdc("unmapped", 5'h1E, 32'hFFFFFFFF, 32'h0);
      $display("test reset done");
   endtask
   task automatic test_normal;
      wr(ADDR_TIME_UNIT, 32'h3);
      for (int i = 0; i < 6; i++) wr(5'(ADDR_SA0 + i), 32'(i + 1));
      launch(8'h25, 8'h28, 16'h0003, 2'h1);
      cmp("lba", 48'h060402050301, readLba);
      cmp("count", 48'h3, {31'h0, readCount});
      cmp("stream", 48'h5, {45'h0, readStream});
      cmp("not seq", 48'h1, {47'h0, readNotSeq});
      rdc("limit", ADDR_LIMIT, 32'h01FFFFFF, 32'h01000078);
      wr(ADDR_COMMAND, {24'h0, CMD_STREAM_READ});
      #1;
      cmp("busy start", 48'h0, {47'h0, readStart});
      mode <= 2'h0;
      wait_done(0);
      cmp("no halt", 48'h0, {47'h0, readHalt});
      rdc("status", ADDR_STATUS, 32'hFF, 32'h0);
      $display("test normal done");
   endtask
   task automatic test_expiry;
      launch(8'h01, 8'h01, 16'h0000, 2'h1);
      cmp("full count", {31'h0, FULL_LENGTH}, {31'h0, readCount});
      rdc("limit", ADDR_LIMIT, 32'h01FFFFFF, {8'h01, MIN_LIMIT_US});
      wait_done(int'(MIN_LIMIT_US));
      cmp("halt", 48'h1, {47'h0, readHalt});
      rdc("left", ADDR_COUNT, 32'h0001FFFF, {15'h0, FULL_LENGTH});
      rdc("status", ADDR_STATUS, 32'hFF, 32'h01);
      rdc("error", ADDR_ERROR, 32'hFF, 32'h01);
      $display("test expiry done");
   endtask
   task automatic test_cont;
      // The stored default is scaled by the time unit too; a unit of one keeps the run short
      wr(ADDR_TIME_UNIT, 32'h1);
      wr(ADDR_CFG_STREAM, 32'h2);
      wr(ADDR_CFG_DEFAULT, 32'h96);
      launch(8'h42, 8'h00, 16'h0005, 2'h2);
      rdc("limit", ADDR_LIMIT, 32'h01FFFFFF, 32'h01000096);
      rdc("stream err", ADDR_STATUS, 32'hFF, 32'hA0);
      wait_done(150);
      cmp("halt", 48'h1, {47'h0, readHalt});
      rdc("extra", ADDR_EXTRA_ST, 32'h7, 32'h6);
      rdc("status", ADDR_STATUS, 32'hFF, 32'h20);
      rdc("error", ADDR_ERROR, 32'hFF, 32'h01);
      $display("test continuous done");
   endtask
   task automatic test_fatal;
      launch(8'h03, 8'h00, 16'h0001, 2'h3);
      wait_done(0);
      rdc("limit on", ADDR_LIMIT, 32'h01000000, 32'h0);
      rdc("status", ADDR_STATUS, 32'hFF, 32'h01);
      rdc("error", ADDR_ERROR, 32'hFF, 32'h04);
      rdc("lba lo", ADDR_LBA_LO, 32'hFFFFFFFF, ERR_LBA[31:0]);
      rdc("lba hi", ADDR_LBA_HI, 32'hFFFF, {16'h0, ERR_LBA[47:32]});
      launch(8'h13, 8'h00, 16'h0001, 2'h0);
      cmp("resume lba", ERR_LBA, readLba);
      wait_done(0);
      $display("test fatal done");
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ======================================================
   // Main sequence and watchdog
   initial
   begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      test_reset;
      test_normal;
      test_expiry;
      test_cont;
      test_fatal;
      test_done;
   end
   // About 50k cycles expected; the limit leaves ample margin
   initial
   begin
      #(CLK_NS * 80000);
      miscompares++;
      test_done;
   end
endmodule
`default_nettype wire
